// file: core/meter_consts.svh
// offsets, field positions, reset values and counts of the meter flag block
// assumes byte addresses on a 32-bit apb bus, one word per register
`ifndef METER_CONSTS_SVH
`define METER_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_PENDING   8'h00
`define OFS_ENABLE    8'h04
`define OFS_PLSCFG1   8'h08
`define OFS_PLSCFG2   8'h0C
`define OFS_CONTROL   8'h10
`define OFS_THRESH1   8'h14
`define OFS_THRESH2   8'h18
`define OFS_WIDTH1    8'h1C
`define OFS_WIDTH2    8'h20
`define OFS_CURLVL    8'h24
`define OFS_VOLTLVL   8'h28
`define OFS_UNDERLVL  8'h2C
`define OFS_VSUMTHR   8'h30
`define OFS_FRAMEDIV  8'h34
`define OFS_PHFLAG0   8'h38
`define OFS_PHOVF0    8'h44

// ----------------------------------------------------------------
// global flag bit positions
// ----------------------------------------------------------------
`define FLG_SUPPLY    0
`define FLG_CHECKSUM  1
`define FLG_ENERGY    2
`define FLG_VSUM      3
`define FLG_CURRENT   4
`define FLG_VOLTAGE   5
`define FLG_UNDER     6
`define FLG_NOZERO    7
`define FLG_REALDIR   8
`define FLG_REACTDIR  9
`define FLG_DONE      10
`define FLG_OVERRUN   11
`define FLG_COUNT     12

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFG_QSEL_LSB  0
`define CFG_PHASE_LSB 4
`define CTL_POLARITY  0
`define RMS_CMP_MSB   23
`define RMS_CMP_LSB   8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WIDTH_RST     16'h009C
`define FRAMEDIV_RST  16'h0167
`define THR_RST       32'hFFFFFFFF
`define HILVL_RST     16'hFFFF
`define LOLVL_RST     16'h0000
`define VSUM_RST      32'hFFFFFFFF

`endif

// file: core/meter_pkg.sv
// types shared by the meter pulse and flag block
// assumes meter_consts.svh is on the include path
`include "meter_consts.svh"
package meter_pkg;
	typedef logic [`FLG_COUNT-1:0] flags_t;
	// per-phase flag copy: current, voltage, under, nozero, realdir, reactdir
	typedef logic [5:0] phase_flags_t;
	// per-phase overflow: bits 4:0 normal set, bits 9:5 fundamental set
	typedef logic [9:0] phase_ovf_t;
endpackage

// file: core/phase_check.sv
// per-phase limit, zero-crossing and direction checks at each dsp cycle end
// assumes all inputs come from logic on the same clock
`timescale 1ns/1ps
`include "meter_consts.svh"
module phase_check (
	input  wire logic                      clock,
	input  wire logic                      resetn,
	input  wire logic                      done,
	input  wire logic                      zeroCross,
	input  wire logic [31:0]               rmsVoltage,
	input  wire logic [31:0]               rmsCurrent,
	input  wire logic [15:0]               currentLimit,
	input  wire logic [15:0]               voltageLimit,
	input  wire logic [15:0]               underLimit,
	input  wire logic                      realSign,
	input  wire logic                      reactSign,
	output meter_pkg::phase_flags_t        events
);
	logic zxSeen;
	logic prevReal;
	logic prevReact;
	logic signValid;
	logic overCur;
	logic overVolt;
	logic underVolt;

	assign overCur   = rmsCurrent[`RMS_CMP_MSB:`RMS_CMP_LSB] > currentLimit;
	assign overVolt  = rmsVoltage[`RMS_CMP_MSB:`RMS_CMP_LSB] > voltageLimit;
	assign underVolt = !(rmsVoltage[`RMS_CMP_MSB:`RMS_CMP_LSB] > underLimit);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			zxSeen    <= 1'b0;
			prevReal  <= 1'b0;
			prevReact <= 1'b0;
			signValid <= 1'b0;
			events    <= '0;
		end else begin
			zxSeen <= done ? zeroCross : (zxSeen | zeroCross);
			events <= '0;
			if (done) begin
				events[0] <= overCur;
				events[1] <= overVolt;
				events[2] <= underVolt;
				events[3] <= !(zxSeen | zeroCross);
				events[4] <= signValid && (realSign != prevReal);
				events[5] <= signValid && (reactSign != prevReact);
				prevReal  <= realSign;
				prevReact <= reactSign;
				signValid <= 1'b1;
			end
		end
	end
endmodule // phase_check

// file: core/pulse_channel.sv
// one meter pulse channel: accumulator, threshold subtraction, width timer
// assumes done and frameTick are one-cycle pulses on the same clock
`timescale 1ns/1ps
module pulse_channel #(
	parameter int NQ = 4,
	parameter int QW = 32,
	parameter int AW = 40
) (
	input  wire logic                      clock,
	input  wire logic                      resetn,
	input  wire logic                      done,
	input  wire logic                      frameTick,
	input  wire logic                      invalid,
	input  wire logic [3*NQ*QW-1:0]        quantity,
	input  wire logic [$clog2(NQ)-1:0]     qsel,
	input  wire logic [2:0]                phaseInclude,
	input  wire logic [31:0]               threshold,
	input  wire logic [15:0]               width,
	input  wire logic                      polarity,
	output logic                           pulseOut
);
	logic [AW-1:0] acc;
	logic [AW-1:0] part [3];
	logic [AW-1:0] next_acc;
	logic [AW-1:0] thrWide;
	logic [15:0]   remain;
	logic          fire;

	for (genvar p = 0; p < 3; p++) begin : g_sel
		assign part[p] = phaseInclude[p] ? AW'(quantity[(p*NQ+int'(qsel))*QW +: QW]) : '0;
	end
	assign thrWide  = AW'(threshold);
	assign next_acc = acc + part[0] + part[1] + part[2];
	assign fire     = done && !invalid && (next_acc > thrWide);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			acc <= '0;
		end else if (done && !invalid) begin
			acc <= fire ? next_acc - thrWide : next_acc;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			remain   <= '0;
			pulseOut <= 1'b1;
		end else begin
			if (fire) begin
				remain <= width;
			end else if (frameTick && remain != 16'h0000) begin
				remain <= remain - 16'h0001;
			end
			pulseOut <= (remain != 16'h0000 && !invalid) ? polarity : !polarity;
		end
	end
endmodule // pulse_channel

// file: core/meter_pulse_flags.sv
// meter pulse generators and sticky event flags behind an apb slave
// assumes dsp status and results arrive on clock; supplyLow is an async pin
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "meter_consts.svh"

module meter_pulse_flags #(
	parameter int NQ = 4,
	parameter int QW = 32
) (
	input  wire logic                      clock,
	input  wire logic                      resetn,
	input  wire logic [7:0]                paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      dspDone,
	input  wire logic                      frameAvail,
	input  wire logic                      dspBusy,
	input  wire logic                      supplyLow,
	input  wire logic [15:0]               configChecksum,
	input  wire logic [31:0]               vectorSum,
	input  wire logic [95:0]               phaseRmsVoltage,
	input  wire logic [95:0]               phaseRmsCurrent,
	input  wire logic [2:0]                zeroCross,
	input  wire logic [2:0]                realSign,
	input  wire logic [2:0]                reactSign,
	input  wire logic [14:0]               energyOverflow,
	input  wire logic [14:0]               fundOverflow,
	input  wire logic [3*NQ*QW-1:0]        phaseQuantity,
	output logic                           irq,
	output logic                           pulseOne,
	output logic                           pulseTwo,
	output logic                           resultsValid
);
	localparam int SW = $clog2(NQ);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	meter_pkg::flags_t       pending;
	meter_pkg::flags_t       enable;
	meter_pkg::flags_t       next_pending;
	meter_pkg::flags_t       setEvents;
	meter_pkg::flags_t       clrMask;
	meter_pkg::phase_flags_t phaseFlags [3];
	meter_pkg::phase_flags_t phaseEvents [3];
	meter_pkg::phase_ovf_t   phaseOvf [3];
	logic [7:0]              pulseCfg1;
	logic [7:0]              pulseCfg2;
	logic                    polarity;
	logic [31:0]             threshold1;
	logic [31:0]             threshold2;
	logic [15:0]             width1;
	logic [15:0]             width2;
	logic [15:0]             currentLimit;
	logic [15:0]             voltageLimit;
	logic [15:0]             underLimit;
	logic [31:0]             vsumThreshold;
	logic [15:0]             frameDiv;
	logic [15:0]             frameCount;
	logic                    frameTick;
	logic                    supplySync1;
	logic                    supplySync2;
	logic [15:0]             prevChecksum;
	logic                    checksumValid;
	logic                    vsumEvent;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire        access   = psel && penable && pready;
	wire        wrAccess = access && pwrite;
	wire        aligned  = paddr[1:0] == 2'b00;
	wire        hitPend  = aligned && paddr == `OFS_PENDING;
	wire        hitEn    = aligned && paddr == `OFS_ENABLE;
	wire        hitCfg1  = aligned && paddr == `OFS_PLSCFG1;
	wire        hitCfg2  = aligned && paddr == `OFS_PLSCFG2;
	wire        hitCtl   = aligned && paddr == `OFS_CONTROL;
	wire        hitPth1  = aligned && paddr == `OFS_THRESH1;
	wire        hitPth2  = aligned && paddr == `OFS_THRESH2;
	wire        hitWd1   = aligned && paddr == `OFS_WIDTH1;
	wire        hitWd2   = aligned && paddr == `OFS_WIDTH2;
	wire        hitCur   = aligned && paddr == `OFS_CURLVL;
	wire        hitVolt  = aligned && paddr == `OFS_VOLTLVL;
	wire        hitUnder = aligned && paddr == `OFS_UNDERLVL;
	wire        hitVsum  = aligned && paddr == `OFS_VSUMTHR;
	wire        hitDiv   = aligned && paddr == `OFS_FRAMEDIV;
	wire [7:0]  flagOfs  = paddr - `OFS_PHFLAG0;
	wire [7:0]  ovfOfs   = paddr - `OFS_PHOVF0;
	wire        hitPhF   = aligned && paddr >= `OFS_PHFLAG0 && flagOfs < 8'h0C;
	wire        hitPhO   = aligned && paddr >= `OFS_PHOVF0 && ovfOfs < 8'h0C;
	wire [1:0]  phFIdx   = flagOfs[3:2];
	wire [1:0]  phOIdx   = ovfOfs[3:2];
	wire        mapped   = hitPend | hitEn | hitCfg1 | hitCfg2 | hitCtl | hitPth1 | hitPth2 |
	                       hitWd1 | hitWd2 | hitCur | hitVolt | hitUnder | hitVsum | hitDiv |
	                       hitPhF | hitPhO;

	wire [31:0] readData =
		hitPend  ? 32'(pending) :
		hitEn    ? 32'(enable) :
		hitCfg1  ? 32'(pulseCfg1) :
		hitCfg2  ? 32'(pulseCfg2) :
		hitCtl   ? 32'(polarity) :
		hitPth1  ? threshold1 :
		hitPth2  ? threshold2 :
		hitWd1   ? 32'(width1) :
		hitWd2   ? 32'(width2) :
		hitCur   ? 32'(currentLimit) :
		hitVolt  ? 32'(voltageLimit) :
		hitUnder ? 32'(underLimit) :
		hitVsum  ? vsumThreshold :
		hitDiv   ? 32'(frameDiv) :
		hitPhF   ? 32'(phaseFlags[phFIdx]) :
		hitPhO   ? 32'(phaseOvf[phOIdx]) :
		32'h00000000;

	// ----------------------------------------------------------------
	// apb answer: one wait state, error on unmapped address
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			prdata  <= (psel && penable && !pready && !pwrite) ? readData : 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			enable     <= '0;
			pulseCfg1  <= 8'h00;
			pulseCfg2  <= 8'h00;
			polarity   <= 1'b0;
			threshold1 <= `THR_RST;
			threshold2 <= `THR_RST;
			width1     <= `WIDTH_RST;
			width2     <= `WIDTH_RST;
		end else if (wrAccess) begin
			if (hitEn)   enable     <= pwdata[`FLG_COUNT-1:0];
			if (hitCfg1) pulseCfg1  <= pwdata[7:0];
			if (hitCfg2) pulseCfg2  <= pwdata[7:0];
			if (hitCtl)  polarity   <= pwdata[`CTL_POLARITY];
			if (hitPth1) threshold1 <= pwdata;
			if (hitPth2) threshold2 <= pwdata;
			if (hitWd1)  width1     <= pwdata[15:0];
			if (hitWd2)  width2     <= pwdata[15:0];
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			currentLimit  <= `HILVL_RST;
			voltageLimit  <= `HILVL_RST;
			underLimit    <= `LOLVL_RST;
			vsumThreshold <= `VSUM_RST;
			frameDiv      <= `FRAMEDIV_RST;
		end else if (wrAccess) begin
			if (hitCur)   currentLimit  <= pwdata[15:0];
			if (hitVolt)  voltageLimit  <= pwdata[15:0];
			if (hitUnder) underLimit    <= pwdata[15:0];
			if (hitVsum)  vsumThreshold <= pwdata;
			if (hitDiv)   frameDiv      <= pwdata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// frame tick divider
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			frameCount <= 16'h0000;
			frameTick  <= 1'b0;
		end else begin
			frameTick  <= frameCount >= frameDiv;
			frameCount <= (frameCount >= frameDiv) ? 16'h0000 : frameCount + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// event sources
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			supplySync1   <= 1'b0;
			supplySync2   <= 1'b0;
			prevChecksum  <= 16'h0000;
			checksumValid <= 1'b0;
		end else begin
			supplySync1   <= supplyLow;
			supplySync2   <= supplySync1;
			prevChecksum  <= configChecksum;
			checksumValid <= 1'b1;
		end
	end

	assign vsumEvent = dspDone && (vectorSum > vsumThreshold);

	for (genvar p = 0; p < 3; p++) begin : g_phase
		phase_check u_check (
			.clock        (clock),
			.resetn       (resetn),
			.done         (dspDone),
			.zeroCross    (zeroCross[p]),
			.rmsVoltage   (phaseRmsVoltage[p*32 +: 32]),
			.rmsCurrent   (phaseRmsCurrent[p*32 +: 32]),
			.currentLimit (currentLimit),
			.voltageLimit (voltageLimit),
			.underLimit   (underLimit),
			.realSign     (realSign[p]),
			.reactSign    (reactSign[p]),
			.events       (phaseEvents[p])
		);

		wire clrFlag = wrAccess && hitPhF && phFIdx == 2'(p);
		wire clrOvf  = wrAccess && hitPhO && phOIdx == 2'(p);
		wire [9:0] ovfIn = {fundOverflow[p*5 +: 5], energyOverflow[p*5 +: 5]};

		always_ff @(posedge clock or negedge resetn) begin
			if (!resetn) begin
				phaseFlags[p] <= '0;
				phaseOvf[p]   <= '0;
			end else begin
				phaseFlags[p] <= (phaseFlags[p] & ~(clrFlag ? pwdata[5:0] : 6'h00))
				                 | phaseEvents[p];
				phaseOvf[p]   <= (phaseOvf[p] & ~(clrOvf ? pwdata[9:0] : 10'h000))
				                 | ovfIn;
			end
		end
	end

	wire [5:0] anyPhase = phaseEvents[0] | phaseEvents[1] | phaseEvents[2];

	always_comb begin
		setEvents                = '0;
		setEvents[`FLG_SUPPLY]   = supplySync2;
		setEvents[`FLG_CHECKSUM] = checksumValid && configChecksum != prevChecksum;
		setEvents[`FLG_ENERGY]   = |{energyOverflow, fundOverflow};
		setEvents[`FLG_VSUM]     = vsumEvent;
		setEvents[`FLG_CURRENT]  = anyPhase[0];
		setEvents[`FLG_VOLTAGE]  = anyPhase[1];
		setEvents[`FLG_UNDER]    = anyPhase[2];
		setEvents[`FLG_NOZERO]   = anyPhase[3];
		setEvents[`FLG_REALDIR]  = anyPhase[4];
		setEvents[`FLG_REACTDIR] = anyPhase[5];
		setEvents[`FLG_DONE]     = dspDone;
		setEvents[`FLG_OVERRUN]  = frameAvail && dspBusy;
	end

	// ----------------------------------------------------------------
	// sticky flags and interrupt
	// ----------------------------------------------------------------
	assign clrMask      = (wrAccess && hitPend) ? pwdata[`FLG_COUNT-1:0] : '0;
	assign next_pending = (pending & ~clrMask) | setEvents;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pending      <= '0;
			irq          <= 1'b0;
			resultsValid <= 1'b0;
		end else begin
			pending      <= next_pending;
			irq          <= |(next_pending & enable);
			resultsValid <= !next_pending[`FLG_OVERRUN];
		end
	end

	// ----------------------------------------------------------------
	// pulse channels
	// ----------------------------------------------------------------
	wire invalid = pending[`FLG_OVERRUN] || setEvents[`FLG_OVERRUN];

	pulse_channel #(.NQ(NQ), .QW(QW)) u_pulse_one (
		.clock        (clock),
		.resetn       (resetn),
		.done         (dspDone),
		.frameTick    (frameTick),
		.invalid      (invalid),
		.quantity     (phaseQuantity),
		.qsel         (pulseCfg1[`CFG_QSEL_LSB +: SW]),
		.phaseInclude (pulseCfg1[`CFG_PHASE_LSB +: 3]),
		.threshold    (threshold1),
		.width        (width1),
		.polarity     (polarity),
		.pulseOut     (pulseOne)
	);

	pulse_channel #(.NQ(NQ), .QW(QW)) u_pulse_two (
		.clock        (clock),
		.resetn       (resetn),
		.done         (dspDone),
		.frameTick    (frameTick),
		.invalid      (invalid),
		.quantity     (phaseQuantity),
		.qsel         (pulseCfg2[`CFG_QSEL_LSB +: SW]),
		.phaseInclude (pulseCfg2[`CFG_PHASE_LSB +: 3]),
		.threshold    (threshold2),
		.width        (width2),
		.polarity     (polarity),
		.pulseOut     (pulseTwo)
	);
endmodule // meter_pulse_flags

// file: tb/meter_flags_properties.sv
// port-level checks of the meter pulse and flag block
// assumes one clock, async active-low reset, apb offsets from the consts header
`timescale 1ns/1ps
`include "meter_consts.svh"
module meter_flags_properties (
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        dspDone,
	input wire logic        frameAvail,
	input wire logic        dspBusy,
	input wire logic        supplyLow,
	input wire logic [15:0] configChecksum,
	input wire logic        irq,
	input wire logic        resultsValid
);
	meter_pkg::flags_t mask;
	logic              hit;
	logic              hitD;
	assign hit = psel && pwrite && (paddr == `OFS_PENDING || paddr == `OFS_ENABLE);
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mask <= '0;
			hitD <= 1'b0;
		end else begin
			hitD <= hit;
			if (psel && penable && pready && pwrite && paddr == `OFS_ENABLE)
				mask <= pwdata[`FLG_COUNT-1:0];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	a_ready_two_late: assert property (psel && !penable |-> ##2 pready)
		else $error("ready not in second access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_unaligned: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr && prdata == 0)
		else $error("unaligned access not refused");
	a_irq_needs_mask: assert property (!(|mask) && !(|$past(mask)) |-> !irq)
		else $error("irq with empty mask");
	a_done_raises_irq: assert property (dspDone && mask[`FLG_DONE] |-> ##[1:2] irq)
		else $error("cycle done gave no irq");
	a_supply_irq: assert property (supplyLow && mask[`FLG_SUPPLY] |-> ##[1:5] irq)
		else $error("supply low gave no irq");
	a_checksum_irq: assert property ($changed(configChecksum) && mask[1] |-> ##[1:3] irq)
		else $error("checksum change gave no irq");
	a_overrun_invalid: assert property (frameAvail && dspBusy |-> ##[1:3] !resultsValid)
		else $error("overrun left results valid");
	a_irq_sticky: assert property (irq && !hit && !hitD |=> irq)
		else $error("irq dropped without host write");
	c_done: cover property (dspDone && mask[`FLG_DONE]);
	c_overrun: cover property (frameAvail && dspBusy);
	c_refused: cover property (pready && pslverr);
endmodule // meter_flags_properties

bind meter_pulse_flags meter_flags_properties u_props (.clock(clock), .resetn(resetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .dspDone(dspDone),
	.frameAvail(frameAvail), .dspBusy(dspBusy), .supplyLow(supplyLow),
	.configChecksum(configChecksum), .irq(irq), .resultsValid(resultsValid));

// file: tb/host_model.sv
// apb host standing in for the controller that services the flags
// assumes one clock shared with the flag block
`timescale 1ns/1ps
module host_model (
	input  wire logic        clock,
	output logic      [7:0]  paddr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		{psel, penable, pwrite} = 3'b000;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		xfer(a, 1'b1, d, q, e);
	endtask
endmodule // host_model

// file: tb/tb_top.sv
// self-checking bench for the meter pulse and flag block
// assumes host_model drives apb and the checker binds itself
`timescale 1ns/1ps
`include "meter_consts.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top;
	logic         clock, resetn, dspDone, frameAvail, dspBusy, supplyLow, err;
	logic         psel, penable, pwrite, pready, pslverr, irq, pulseOne, pulseTwo, valid;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, vectorSum, rd, r, lvl;
	logic [15:0]  checksum;
	logic [95:0]  rmsV, rmsI;
	logic [2:0]   zx, realS, reactS, ph, ex;
	logic [14:0]  energy_overflow_flag, fOvf;
	logic [383:0] qty;
	int           error_cnt, cmp_count, cyc;
	meter_pulse_flags dut (.clock, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .dspDone, .frameAvail, .dspBusy, .supplyLow,
		.configChecksum(checksum), .vectorSum, .phaseRmsVoltage(rmsV), .phaseRmsCurrent(rmsI),
		.zeroCross(zx), .realSign(realS), .reactSign(reactS), .energyOverflow(energy_overflow_flag),
		.fundOverflow(fOvf), .phaseQuantity(qty), .irq, .pulseOne, .pulseTwo,
		.resultsValid(valid));
	host_model host (.clock, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr);
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic rchk(input logic [7:0] a, input logic [31:0] x);
		host.xfer(a, 1'b0, 32'h0, rd, err);
		`CHK(rd, x)
	endtask
	// expected current, voltage and undervoltage bits of one phase
	function automatic logic [2:0] phaseExp(input logic [31:0] v, input logic [31:0] i,
		input logic [15:0] hi, input logic [15:0] lo);
		return {!(v[23:8] > lo), v[23:8] > hi, i[23:8] > 16'h0100};
	endfunction
	task automatic dsp(input logic [2:0] z);
		zx <= z;
		@(posedge clock);
		zx <= 3'b000;
		dspDone <= 1'b1;
		@(posedge clock);
		dspDone <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	task automatic complete_run();
		if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			complete_run();
		end
	end
	initial begin
		void'($urandom(32'h6A9DD442));
		{resetn, dspDone, frameAvail, dspBusy, supplyLow, zx, realS, reactS} = '0;
		{energy_overflow_flag, fOvf, rmsI, qty, vectorSum, checksum} = '0;
		rmsV = {3{32'h0000_1000}};
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		rchk(`OFS_WIDTH1, 32'h0000_009C);
		rchk(`OFS_THRESH1, `THR_RST);
		rchk(`OFS_CURLVL, 32'h0000_FFFF);
		rchk(`OFS_ENABLE, 32'h0);
		rchk(8'h80, 32'h0);
		`CHK(err, 1'b1)
		rchk(8'h05, 32'h0);
		`CHK(err, 1'b1)
		host.wr(`OFS_ENABLE, 32'h0000_0FFF);
		dsp(3'b111);
		rchk(`OFS_PENDING, 32'h0000_0400);
		`CHK(irq, 1'b1)
		host.wr(`OFS_PENDING, 32'h0000_0FFF);
		rchk(`OFS_PENDING, 32'h0);
		`CHK(irq, 1'b0)
		r = $urandom & 32'h7FFF_FFFF;
		host.wr(`OFS_VSUMTHR, r);
		host.wr(`OFS_CURLVL, 32'h0000_0100);
		vectorSum <= r + 32'h1;
		rmsI <= {32'h0, 32'h0001_0100, 32'h0001_0000};
		realS <= 3'b010;
		reactS <= 3'b100;
		dsp(3'b011);
		rchk(`OFS_PENDING, 32'h0000_0798);
		rchk(`OFS_PHFLAG0, 32'h0);
		rchk(8'h3C, 32'h0000_0011);
		rchk(8'h40, 32'h0000_0028);
		host.wr(`OFS_PENDING, 32'h0000_0FFF);
		supplyLow <= 1'b1;
		checksum <= 16'($urandom) | 16'h0001;
		energy_overflow_flag <= 15'h0400;
		fOvf <= 15'h0002;
		@(posedge clock);
		{supplyLow, energy_overflow_flag, fOvf} <= '0;
		repeat (8) @(posedge clock);
		rchk(`OFS_PENDING, 32'h0000_0007);
		rchk(`OFS_PHOVF0, 32'h0000_0040);
		rchk(8'h4C, 32'h0000_0001);
		repeat (20) @(posedge clock);
		rchk(`OFS_PENDING, 32'h0000_0007);
		host.wr(`OFS_PENDING, 32'h0000_0FFF);
		{dspBusy, frameAvail} <= 2'b11;
		@(posedge clock);
		{dspBusy, frameAvail} <= 2'b00;
		repeat (3) @(posedge clock);
		`CHK(valid, 1'b0)
		rchk(`OFS_PENDING, 32'h0000_0800);
		host.wr(`OFS_PENDING, 32'h0000_0FFF);
		@(posedge clock);
		`CHK(valid, 1'b1)
		host.wr(`OFS_FRAMEDIV, 32'h1);
		host.wr(`OFS_WIDTH1, 32'h8);
		host.wr(`OFS_THRESH1, 32'd100);
		host.wr(`OFS_THRESH2, 32'd70);
		host.wr(`OFS_PLSCFG1, 32'h10);
		host.wr(`OFS_PLSCFG2, 32'h41);
		qty <= {64'h0, 32'd40, 128'h0, $urandom | 32'd100, 96'h0, 32'd60};
		dsp(3'b111);
		`CHK(pulseOne, 1'b1)
		`CHK(pulseTwo, 1'b1)
		dsp(3'b111);
		`CHK(pulseOne, 1'b0)
		`CHK(pulseTwo, 1'b0)
		repeat (20) @(posedge clock);
		`CHK(pulseOne, 1'b1)
		`CHK(pulseTwo, 1'b0)
		host.wr(`OFS_CONTROL, 32'h1);
		@(posedge clock);
		`CHK(pulseOne, 1'b0)
		`CHK(pulseTwo, 1'b1)
		lvl = $urandom;
		host.wr(`OFS_VOLTLVL, {16'h0000, lvl[15:0]});
		host.wr(`OFS_UNDERLVL, {16'h0000, lvl[31:16]});
		rmsV <= {$urandom, $urandom, $urandom};
		for (int p = 0; p < 3; p++) begin
			host.wr(`OFS_PHFLAG0 + 8'(4 * p), 32'h0000_003F);
		end
		host.wr(`OFS_PENDING, 32'h0000_0FFF);
		dsp(3'b111);
		ex = 3'b000;
		for (int p = 0; p < 3; p++) begin
			ph = phaseExp(rmsV[p*32 +: 32], rmsI[p*32 +: 32], lvl[15:0], lvl[31:16]);
			ex = ex | ph;
			rchk(`OFS_PHFLAG0 + 8'(4 * p), 32'(ph));
		end
		rchk(`OFS_PENDING, 32'h0000_0408 | (32'(ex) << 4));
		complete_run();
	end
endmodule // tb_top
